// ===== rtl/ctsc_regs.svh
`ifndef CTSC_REGS_SVH
`define CTSC_REGS_SVH

// register offsets on the serial register port
`define CTSC_ADDR_EN_LOW      8'h72
`define CTSC_ADDR_EN_HIGH     8'h73
`define CTSC_ADDR_CAL_PERIOD  8'h76
`define CTSC_ADDR_CAL_SCHEME  8'h77
`define CTSC_ADDR_MEDIAN      8'h78
`define CTSC_ADDR_VIEW        8'h7C
`define CTSC_ADDR_READOUT     8'hC0
`define CTSC_READOUT_TOP      3'h6

// field positions
`define CTSC_MULT_LSB         6
`define CTSC_INTERVAL_MSB     5
`define CTSC_SPACING_LSB      3
`define CTSC_MODEL_LSB        1
`define CTSC_CAL_EN_BIT       0
`define CTSC_FILT_DEPTH_LSB   1
`define CTSC_FILT_ON_BIT      0

// reset values
`define CTSC_RST_EN           8'h00
`define CTSC_RST_CAL_PERIOD   8'h00
`define CTSC_RST_CAL_SCHEME   8'h00
`define CTSC_RST_MEDIAN       3'h0
`define CTSC_RST_VIEW         8'h00

// timing and processing constants
`define CTSC_CLK_HZ           20000000
`define CTSC_TICK_MS          10
`define CTSC_MULT_BASE_SHIFT  3
`define CTSC_SAMPLES_PER_CAL  4'h8
`define CTSC_AVG_SHIFT        3
`define CTSC_THR_SHIFT        4
`define CTSC_TUNE_LOW         13'h0100
`define CTSC_TUNE_HIGH        13'h1F00
`define CTSC_DELAY_MAX        6'h3F

`endif

// ===== rtl/ctsc_pkg.sv
package ctsc_pkg;

  typedef enum logic [7:0] {
    VIEW_NONE   = 8'h00,
    VIEW_TOUCH  = 8'h01,
    VIEW_DRIFT  = 8'h02,
    VIEW_DELAY  = 8'h03,
    VIEW_LIVE   = 8'h04,
    VIEW_CAL    = 8'h05,
    VIEW_FROZEN = 8'h06
  } ctsc_view_t;

  typedef enum logic [1:0] {
    MODEL_PLAIN    = 2'h0,
    MODEL_AUTOTUNE = 2'h2
  } ctsc_model_t;

  typedef enum logic [2:0] {
    CAL_IDLE   = 3'h1,
    CAL_WAIT   = 3'h2,
    CAL_GATHER = 3'h4
  } ctsc_cal_state_t;

endpackage

// ===== rtl/ctsc_tick_div.sv
`timescale 1ns/10ps
module ctsc_tick_div #(
  parameter int TICK_CYCLES = 200000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // one-cycle pulse every TICK_CYCLES clocks
  output logic      tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] count;
  wire           wrap = (count == LAST);

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= wrap ? '0 : count + CW'(1);
      tick  <= wrap;
    end
  end
endmodule

// ===== rtl/ctsc_core.sv
`timescale 1ns/10ps
`include "ctsc_regs.svh"
module ctsc_core
  import ctsc_pkg::*;
#(
  parameter int NCH         = 16,
  parameter int TICK_CYCLES = `CTSC_CLK_HZ / 1000 * `CTSC_TICK_MS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // serial register port, byte wide
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  // samples from the sensing front end
  input  wire logic        sampleValid,
  input  wire logic [3:0]  sampleChannel,
  input  wire logic [12:0] sampleImpedance,
  // configuration towards the front end
  output logic [NCH-1:0]   channelEnable,
  output logic             filterOn,
  output logic [4:0]       filterSamples,
  output logic [2:0]       filterDiscard,
  output logic             autoTuneMode,
  // status
  output logic [NCH-1:0]   touchFlags,
  output logic [NCH-1:0]   retunePulse,
  output logic             calBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  function automatic logic [12:0] absDiff(input logic [12:0] a,
                                          input logic [12:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // config registers
  logic [7:0] enLow;
  logic [7:0] enHigh;
  logic [7:0] calPeriod;
  logic [7:0] calScheme;
  logic [2:0] medianCfg;
  logic [7:0] viewSel;

  // address decode
  wire        wrEnLow   = regWrite && regAddr == `CTSC_ADDR_EN_LOW;
  wire        wrEnHigh  = regWrite && regAddr == `CTSC_ADDR_EN_HIGH;
  wire        wrPeriod  = regWrite && regAddr == `CTSC_ADDR_CAL_PERIOD;
  wire        wrScheme  = regWrite && regAddr == `CTSC_ADDR_CAL_SCHEME;
  wire        wrMedian  = regWrite && regAddr == `CTSC_ADDR_MEDIAN;
  wire        wrView    = regWrite && regAddr == `CTSC_ADDR_VIEW;
  wire        inReadout = regAddr[7:5] == `CTSC_READOUT_TOP;
  wire        wrChan    = regWrite && inReadout;
  wire [3:0]  chIdx     = regAddr[4:1];
  wire        hiByte    = regAddr[0];

  // derived fields
  wire [1:0]  multCode  = calPeriod[7:`CTSC_MULT_LSB];
  wire [5:0]  interval  = calPeriod[`CTSC_INTERVAL_MSB:0];
  wire [4:0]  spacing   = calScheme[7:`CTSC_SPACING_LSB];
  wire [1:0]  model     = calScheme[`CTSC_MODEL_LSB+1:`CTSC_MODEL_LSB];
  wire        calEnable = calScheme[`CTSC_CAL_EN_BIT];
  wire [1:0]  filtDepth = medianCfg[`CTSC_FILT_DEPTH_LSB+1:
                                    `CTSC_FILT_DEPTH_LSB];
  // factor 8 shifted by two bits per code step
  wire [3:0]  multShift = 4'(`CTSC_MULT_BASE_SHIFT) + {1'b0, multCode, 1'b0};
  wire [14:0] periodTicks = 15'(interval) << multShift;
  // spacing in 10 ms ticks, at least one
  wire [4:0]  spaceTicks = (spacing == 5'h00) ? 5'h01 : spacing;

  assign autoTuneMode  = model == MODEL_AUTOTUNE;
  assign channelEnable = {enHigh, enLow};
  assign filterOn      = medianCfg[`CTSC_FILT_ON_BIT];
  assign filterSamples = (filtDepth == 2'h1) ? 5'h12 :
                         (filtDepth == 2'h2) ? 5'h14 : 5'h0A;
  assign filterDiscard = (filtDepth == 2'h2) ? 3'h4 : 3'h2;

  // capture only on entry into the frozen view
  // staying in the view never recaptures
  wire freezeCapture = wrView && regWrData == VIEW_FROZEN &&
                       viewSel != VIEW_FROZEN;

  always_ff @(posedge clk) begin
    if (reset) begin
      enLow     <= `CTSC_RST_EN;
      enHigh    <= `CTSC_RST_EN;
      calPeriod <= `CTSC_RST_CAL_PERIOD;
      calScheme <= `CTSC_RST_CAL_SCHEME;
      medianCfg <= `CTSC_RST_MEDIAN;
      viewSel   <= `CTSC_RST_VIEW;
    end else begin
      if (wrEnLow)  enLow     <= regWrData;
      if (wrEnHigh) enHigh    <= regWrData;
      if (wrPeriod) calPeriod <= regWrData;
      if (wrScheme) calScheme <= regWrData;
      if (wrMedian) medianCfg <= regWrData[2:0];
      if (wrView)   viewSel   <= regWrData;
    end
  end

  // 10 ms time base
  logic tick;
  ctsc_tick_div #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  // calibration sequencer
  ctsc_cal_state_t state;
  ctsc_cal_state_t next_state;
  logic [14:0] periodCnt;
  logic [4:0]  spaceCnt;
  logic [3:0]  takeCnt;
  logic        calDone;
  int unsigned sinceTake;

  wire periodEnd   = state == CAL_WAIT && tick &&
                     periodCnt == periodTicks - 15'h1;
  wire spaceEnd    = state == CAL_GATHER && tick &&
                     spaceCnt == spaceTicks - 5'h01;
  wire gatherStart = periodEnd;
  wire gatherTake  = spaceEnd;
  wire lastTake    = gatherTake &&
                     takeCnt == `CTSC_SAMPLES_PER_CAL - 4'h1;

  // sequencer runs only while calibration is enabled
  always_comb begin
    next_state = state;
    unique case (state)
      CAL_IDLE:
        if (calEnable && periodTicks != 15'h0) next_state = CAL_WAIT;
      CAL_WAIT:
        if (!calEnable) next_state = CAL_IDLE;
        else if (periodEnd) next_state = CAL_GATHER;
      CAL_GATHER:
        if (!calEnable) next_state = CAL_IDLE;
        else if (lastTake) next_state = CAL_WAIT;
      default: next_state = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= CAL_IDLE;
      periodCnt <= 15'h0;
      spaceCnt  <= 5'h00;
      takeCnt   <= 4'h0;
      calDone   <= 1'b0;
      sinceTake <= 32'h1;
    end else begin
      state     <= next_state;
      calDone   <= lastTake && calEnable;
      sinceTake <= (gatherStart || gatherTake) ? 32'h1 : sinceTake + 32'h1;
      if (state != CAL_WAIT || periodEnd) periodCnt <= 15'h0;
      else if (tick) periodCnt <= periodCnt + 15'h1;
      if (state != CAL_GATHER || spaceEnd) spaceCnt <= 5'h00;
      else if (tick) spaceCnt <= spaceCnt + 5'h01;
      if (gatherStart || lastTake || state == CAL_IDLE) takeCnt <= 4'h1;
      else if (gatherTake) takeCnt <= takeCnt + 4'h1;
    end
  end
  assign calBusy = state == CAL_GATHER;

  // per-channel state
  logic [8:0]  touchThr  [NCH];
  logic [8:0]  driftThr  [NCH];
  logic [5:0]  chDelay   [NCH];
  logic [12:0] liveImp   [NCH];
  logic [12:0] calImp    [NCH];
  logic [12:0] frozenImp [NCH];
  logic [NCH*6-1:0] delayFlat;
  logic [NCH*13-1:0] frozenFlat;
  logic [NCH*13-1:0] calFlat;

  genvar n;
  generate
    for (n = 0; n < NCH; n++) begin : g_ch
      logic [8:0]  thr;
      logic [8:0]  drift;
      logic [5:0]  dly;
      logic [12:0] live;
      logic [12:0] cal;
      logic [12:0] frozen;
      logic [15:0] accum;
      logic        touched;
      logic        retune;

      wire        sel     = wrChan && chIdx == 4'(n);
      wire        mySample = sampleValid && sampleChannel == 4'(n);
      wire [12:0] avg     = accum[15:`CTSC_AVG_SHIFT];
      wire        tooLow  = mySample && sampleImpedance < `CTSC_TUNE_LOW;
      wire        tooHigh = mySample && sampleImpedance > `CTSC_TUNE_HIGH;
      wire [12:0] thrWide   = {thr, 4'h0};
      wire [12:0] driftWide = {drift, 4'h0};

      always_ff @(posedge clk) begin
        if (reset) begin
          thr     <= 9'h000;
          drift   <= 9'h000;
          dly     <= 6'h00;
          live    <= 13'h0000;
          cal     <= 13'h0000;
          frozen  <= 13'h0000;
          accum   <= 16'h0000;
          touched <= 1'b0;
          retune  <= 1'b0;
        end else begin
          // live value follows every front-end sample of its own channel
          if (mySample) live <= sampleImpedance;
          // threshold writes through the data port
          if (sel && viewSel == VIEW_TOUCH) begin
            if (hiByte) thr[8] <= regWrData[0];
            else thr[7:0] <= regWrData;
          end
          if (sel && viewSel == VIEW_DRIFT) begin
            if (hiByte) drift[8] <= regWrData[0];
            else drift[7:0] <= regWrData;
          end
          // delay locked to the host while auto-tuning
          // delay saturates within 0 to 63
          retune <= autoTuneMode && (tooLow || tooHigh);
          if (autoTuneMode) begin
            if (tooLow && dly != `CTSC_DELAY_MAX) dly <= dly + 6'h01;
            else if (tooHigh && dly != 6'h00) dly <= dly - 6'h01;
          end else if (sel && viewSel == VIEW_DELAY && !hiByte) begin
            dly <= regWrData[5:0];
          end
          if (freezeCapture) frozen <= live;
          if (gatherStart) accum <= 16'(live);
          else if (gatherTake) accum <= accum + 16'(live);
          // small drift pulls the reference; first event seeds it
          if (calDone &&
              (cal == 13'h0000 || absDiff(avg, cal) < driftWide))
            cal <= avg;
          touched <= channelEnable[n] && cal != 13'h0000 &&
                     absDiff(live, cal) > thrWide;
        end
      end

      assign touchThr[n]  = thr;
      assign driftThr[n]  = drift;
      assign chDelay[n]   = dly;
      assign liveImp[n]   = live;
      assign calImp[n]    = cal;
      assign frozenImp[n] = frozen;
      assign touchFlags[n]  = touched;
      assign retunePulse[n] = retune;
      assign delayFlat[n*6 +: 6]    = dly;
      assign frozenFlat[n*13 +: 13] = frozen;
      assign calFlat[n*13 +: 13]    = cal;
    end
  endgenerate

  // readout selection
  // threshold, delay, live, calibrated and frozen impedance views
  wire [15:0] chanWord =
    (viewSel == VIEW_TOUCH)  ? 16'(touchThr[chIdx])  :
    (viewSel == VIEW_DRIFT)  ? 16'(driftThr[chIdx])  :
    (viewSel == VIEW_DELAY)  ? 16'(chDelay[chIdx])   :
    (viewSel == VIEW_LIVE)   ? 16'(liveImp[chIdx])   :
    (viewSel == VIEW_CAL)    ? 16'(calImp[chIdx])    :
    (viewSel == VIEW_FROZEN) ? 16'(frozenImp[chIdx]) : 16'h0000;

  wire [7:0] readByte =
    (regAddr == `CTSC_ADDR_EN_LOW)     ? enLow                  :
    (regAddr == `CTSC_ADDR_EN_HIGH)    ? enHigh                 :
    (regAddr == `CTSC_ADDR_CAL_PERIOD) ? calPeriod              :
    (regAddr == `CTSC_ADDR_CAL_SCHEME) ? calScheme              :
    (regAddr == `CTSC_ADDR_MEDIAN)     ? {5'h00, medianCfg}     :
    (regAddr == `CTSC_ADDR_VIEW)       ? viewSel                :
    // low then high byte of a channel word
    inReadout ? (hiByte ? chanWord[15:8] : chanWord[7:0]) : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) regRdData <= 8'h00;
    else if (regRead) regRdData <= readByte;
  end

  // checks
  sequence sFreezeEntry;
    freezeCapture;
  endsequence
  sequence sHeld;
    viewSel == VIEW_FROZEN && !freezeCapture;
  endsequence

  a_enable_high: assert property (
    wrEnHigh |=> channelEnable[15:8] == $past(regWrData))
    else $error("enable map upper byte not taken");
  a_period_factor: assert property (
    multCode == 2'h3 |-> periodTicks == 15'(interval) * 15'h200)
    else $error("period multiplier wrong");
  a_period_end: assert property (
    periodEnd && calEnable |=> state == CAL_GATHER ##0 takeCnt == 4'h1)
    else $error("calibration event not started at period end");
  a_spacing_take: assert property (
    gatherTake |-> sinceTake == 32'(spaceTicks) * 32'(TICK_CYCLES))
    else $error("sample taken off spacing");
  a_delay_lock: assert property (
    wrChan && viewSel == VIEW_DELAY && autoTuneMode && !sampleValid
    |=> $stable(delayFlat))
    else $error("delay written while auto-tuning");
  a_filter_depth: assert property (
    filtDepth == 2'h1 |-> filterSamples == 5'h12 && filterDiscard == 3'h2)
    else $error("filter depth decode wrong");
  a_touch_chan0: assert property (
    channelEnable[0] && calImp[0] != 13'h0000 &&
    absDiff(liveImp[0], calImp[0]) > {touchThr[0], 4'h0}
    |=> touchFlags[0])
    else $error("touch not flagged");
  a_frozen_take: assert property (
    sFreezeEntry |=> frozenImp[0] == $past(liveImp[0]))
    else $error("frozen set not captured");
  a_frozen_hold: assert property (
    sHeld ##1 sHeld |-> $stable(frozenFlat))
    else $error("frozen set changed while held");
  a_eight_takes: assert property (
    lastTake && calEnable |-> takeCnt == 4'h7 ##1 calDone)
    else $error("calibration did not complete after eight samples");
  a_ref_only_cal: assert property (
    !calDone |=> $stable(calFlat))
    else $error("reference changed outside calibration");
  a_unknown_view: assert property (
    viewSel > VIEW_FROZEN || viewSel == VIEW_NONE |-> chanWord == 16'h0000)
    else $error("undefined view not zero");
endmodule

// ===== test/ctsc_front_model.sv
`timescale 1ns/10ps
module ctsc_front_model #(
  parameter int GAP = 2
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // enable map from the core
  input  wire logic [15:0] channelEnable,
  // sample stream into the core
  output logic             sampleValid,
  output logic [3:0]       sampleChannel,
  output logic [12:0]      sampleImpedance
);
  logic [12:0] imp [16];
  logic [3:0]  scanIdx;
  int          gapCnt;

  // impedance seen on one electrode, lower means more capacitance
  task automatic set_imp(input logic [3:0] ch, input logic [12:0] val);
    imp[ch] = val;
  endtask

  initial begin
    for (int i = 0; i < 16; i++) begin
      imp[i] = 13'h1000;
    end
  end

  // scan one slot per GAP clocks, outside a sample the lines toggle
  always @(posedge clk) begin
    if (reset) begin
      sampleValid <= 1'b0;
      sampleChannel <= 4'h0;
      sampleImpedance <= 13'h0000;
      scanIdx <= 4'h0;
      gapCnt <= 0;
    end else begin
      sampleValid <= 1'b0;
      sampleChannel <= ~sampleChannel;
      sampleImpedance <= ~sampleImpedance;
      gapCnt <= gapCnt + 1;
      if (gapCnt >= GAP - 1) begin
        gapCnt <= 0;
        scanIdx <= scanIdx + 4'h1;
        if (channelEnable[scanIdx]) begin
          sampleValid <= 1'b1;
          sampleChannel <= scanIdx;
          sampleImpedance <= imp[scanIdx];
        end
      end
    end
  end
endmodule

// ===== test/capacitive_touch_sensor_core_test.sv
`timescale 1ns/10ps
`include "ctsc_regs.svh"
module capacitive_touch_sensor_core_test
  import ctsc_pkg::*;
;
  localparam int TICK = 4;
  logic        clk;
  logic        reset;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWrite;
  logic        regRead;
  logic [7:0]  regRdData;
  logic [15:0] channelEnable;
  logic        filterOn;
  logic [4:0]  filterSamples;
  logic [2:0]  filterDiscard;
  logic        autoTuneMode;
  logic [15:0] touchFlags;
  logic [15:0] retunePulse;
  logic        calBusy;
  logic        sampleValid;
  logic [3:0]  sampleChannel;
  logic [12:0] sampleImpedance;
  logic [4:0]  fSamp [4] = '{5'h0A, 5'h12, 5'h14, 5'h0A};
  logic [2:0]  fDisc [4] = '{3'h2, 3'h2, 3'h4, 3'h2};
  int          errors;
  int          n_tests;
  int          cycles;
  int          n;
  int          expN;

  ctsc_core #(.NCH(16), .TICK_CYCLES(TICK)) i_ctsc_core (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .sampleValid(sampleValid), .sampleChannel(sampleChannel),
    .sampleImpedance(sampleImpedance), .channelEnable(channelEnable),
    .filterOn(filterOn), .filterSamples(filterSamples),
    .filterDiscard(filterDiscard), .autoTuneMode(autoTuneMode),
    .touchFlags(touchFlags), .retunePulse(retunePulse), .calBusy(calBusy));

  ctsc_front_model #(.GAP(2)) i_ctsc_front_model (
    .clk(clk), .reset(reset), .channelEnable(channelEnable),
    .sampleValid(sampleValid), .sampleChannel(sampleChannel),
    .sampleImpedance(sampleImpedance));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({8'h00, regRdData}, {8'h00, exp}, $sformatf("read %h", a));
  endtask

  task automatic rdw(input logic [3:0] ch, input logic [15:0] exp);
    rd(`CTSC_ADDR_READOUT | {3'h0, ch, 1'b0}, exp[7:0]);
    rd(`CTSC_ADDR_READOUT | {3'h0, ch, 1'b1}, exp[15:8]);
  endtask

  task automatic wrw(input logic [3:0] ch, input logic [15:0] val);
    wr(`CTSC_ADDR_READOUT | {3'h0, ch, 1'b0}, val[7:0]);
    wr(`CTSC_ADDR_READOUT | {3'h0, ch, 1'b1}, val[15:8]);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: pick = calBusy;
      1: pick = touchFlags[0];
      default: pick = retunePulse[9];
    endcase
  endfunction

  // bounded wait for an output level, n holds the cycles spent
  task automatic waitv(input int w, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pick(w) !== v && n < lim);
  endtask

  task automatic calibrate();
    waitv(0, 1'b1, 100);
    waitv(0, 1'b0, 200);
  endtask

  initial begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    errors = 0;
    n_tests = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(channelEnable, 16'h0000, "enable rst");
    chk({8'h00, filterSamples, filterDiscard}, 16'h0052, "filt rst");
    rd(`CTSC_ADDR_CAL_PERIOD, 8'h00);
    rd(`CTSC_ADDR_CAL_SCHEME, 8'h00);
    rd(`CTSC_ADDR_MEDIAN, 8'h00);
    rd(`CTSC_ADDR_VIEW, 8'h00);
    rd(8'h7F, 8'h00);
    rdw(4'h0, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(`CTSC_ADDR_MEDIAN, 8'hF8 | 8'((c << 1) | (c & 1)));
      rd(`CTSC_ADDR_MEDIAN, 8'((c << 1) | (c & 1)));
      chk({8'h00, filterSamples, filterDiscard},
          {8'h00, fSamp[c], fDisc[c]}, "depth");
      chk({15'h0, filterOn}, 16'(c & 1), "filter on");
      wr(`CTSC_ADDR_CAL_SCHEME, 8'(c << 1));
      rd(`CTSC_ADDR_CAL_SCHEME, 8'(c << 1));
      chk({15'h0, autoTuneMode}, 16'(c == 2), "model");
    end
    wr(`CTSC_ADDR_EN_LOW, 8'h01);
    wr(`CTSC_ADDR_EN_HIGH, 8'h02);
    rd(`CTSC_ADDR_EN_HIGH, 8'h02);
    chk(channelEnable, 16'h0201, "enable map");
    i_ctsc_front_model.set_imp(4'h0, 13'h0800);
    i_ctsc_front_model.set_imp(4'h9, 13'h0A5C);
    repeat (40) @(posedge clk);
    wr(`CTSC_ADDR_VIEW, VIEW_LIVE);
    rdw(4'h0, 16'h0800);
    rdw(4'h9, 16'h0A5C);
    wrw(4'h9, 16'h0123);
    rdw(4'h9, 16'h0A5C);
    wr(`CTSC_ADDR_VIEW, VIEW_TOUCH);
    wrw(4'h9, 16'h01AB);
    wrw(4'h0, 16'h0001);
    rdw(4'h9, 16'h01AB);
    wr(`CTSC_ADDR_VIEW, VIEW_DRIFT);
    wrw(4'h9, 16'h0155);
    rdw(4'h9, 16'h0155);
    rdw(4'h0, 16'h0000);
    wr(`CTSC_ADDR_VIEW, VIEW_DELAY);
    wr(`CTSC_ADDR_CAL_SCHEME, 8'h00);
    wrw(4'h0, 16'h0015);
    rdw(4'h0, 16'h0015);
    wr(`CTSC_ADDR_CAL_SCHEME, 8'h04);
    wrw(4'h0, 16'h002A);
    rdw(4'h0, 16'h0015);
    i_ctsc_front_model.set_imp(4'h9, 13'h0050);
    waitv(2, 1'b1, 100);
    chk(16'(n < 100), 16'h0001, "retune");
    repeat (2200) @(posedge clk);
    rdw(4'h9, 16'h003F);
    i_ctsc_front_model.set_imp(4'h9, 13'h1F80);
    repeat (2200) @(posedge clk);
    rdw(4'h9, 16'h0000);
    i_ctsc_front_model.set_imp(4'h9, 13'h0A5C);
    wr(`CTSC_ADDR_CAL_SCHEME, 8'h00);
    wr(`CTSC_ADDR_VIEW, 8'h07);
    rdw(4'h9, 16'h0000);
    wr(`CTSC_ADDR_VIEW, VIEW_FROZEN);
    i_ctsc_front_model.set_imp(4'h0, 13'h0900);
    repeat (40) @(posedge clk);
    rdw(4'h0, 16'h0800);
    wr(`CTSC_ADDR_VIEW, VIEW_FROZEN);
    rdw(4'h0, 16'h0800);
    wr(`CTSC_ADDR_VIEW, VIEW_NONE);
    wr(`CTSC_ADDR_VIEW, VIEW_FROZEN);
    rdw(4'h0, 16'h0900);
    i_ctsc_front_model.set_imp(4'h0, 13'h0800);
    wr(`CTSC_ADDR_CAL_PERIOD, 8'h01);
    waitv(0, 1'b1, 100);
    chk(16'(n), 16'h0064, "cal off");
    for (int c = 0; c < 4; c++) begin
      wr(`CTSC_ADDR_CAL_SCHEME, 8'h00);
      wr(`CTSC_ADDR_CAL_PERIOD, 8'(c << 6) | 8'h01);
      wr(`CTSC_ADDR_CAL_SCHEME, 8'h09);
      waitv(0, 1'b1, 3000);
      expN = (8 << (2 * c)) * TICK;
      chk(16'(n >= expN - 5 && n <= expN + 5), 16'h0001,
          "period");
    end
    wr(`CTSC_ADDR_CAL_SCHEME, 8'h00);
    wr(`CTSC_ADDR_CAL_PERIOD, 8'h01);
    wr(`CTSC_ADDR_CAL_SCHEME, 8'h11);
    calibrate();
    chk(16'(n >= 52 && n <= 61), 16'h0001, "spacing");
    wr(`CTSC_ADDR_CAL_SCHEME, 8'h00);
    wr(`CTSC_ADDR_VIEW, VIEW_CAL);
    rdw(4'h0, 16'h0800);
    wrw(4'h0, 16'h0123);
    rdw(4'h0, 16'h0800);
    i_ctsc_front_model.set_imp(4'h0, 13'h07EF);
    waitv(1, 1'b1, 80);
    chk({15'h0, touchFlags[0]}, 16'h0001, "touch");
    i_ctsc_front_model.set_imp(4'h0, 13'h07F0);
    waitv(1, 1'b0, 80);
    chk({15'h0, touchFlags[0]}, 16'h0000, "no touch");
    wr(`CTSC_ADDR_VIEW, VIEW_DRIFT);
    wrw(4'h0, 16'h0002);
    i_ctsc_front_model.set_imp(4'h0, 13'h0810);
    repeat (40) @(posedge clk);
    // second pass moves too far, reference must hold
    for (int k = 0; k < 2; k++) begin
      wr(`CTSC_ADDR_CAL_SCHEME, 8'h11);
      calibrate();
      wr(`CTSC_ADDR_CAL_SCHEME, 8'h00);
      wr(`CTSC_ADDR_VIEW, VIEW_CAL);
      rdw(4'h0, 16'h0810);
      i_ctsc_front_model.set_imp(4'h0, 13'h0900);
      repeat (40) @(posedge clk);
    end
    final_report();
  end
endmodule
